/* File: pkg/adctp_pkg.sv */
// ==========
// Constants shared by the pattern and sleep control block.
// ==========
package adctp_pkg;

    // ==========
    // Register addresses as carried in the address word.
    // ==========
    localparam logic [7:0] ADDR_MODE     = 8'h01;
    localparam logic [7:0] ADDR_SLEEP    = 8'h37;
    localparam logic [7:0] ADDR_PAT_CTL  = 8'h3C;
    localparam logic [7:0] ADDR_PAT_VAL  = 8'h3D;
    localparam logic [7:0] ADDR_PAT_ALT  = 8'h3E;

    // ==========
    // Serial frame layout and register fields.
    // ==========
    localparam int          ADDR_BITS    = 8;
    localparam int          DATA_BITS    = 16;
    localparam int          FRAME_BITS   = ADDR_BITS + DATA_BITS;
    localparam int          RW_BIT       = 7;
    localparam int          HIGH_PERF_BIT = 1;
    localparam int          PAT_EN_BIT   = 15;
    localparam int          SMP_MSB      = 13;
    localparam int          SMP_LSB      = 2;
    localparam int          SMP_BITS     = 12;
    localparam logic [15:0] MODE_RESET   = 16'h0002;
    localparam logic [15:0] SLEEP_RESET  = 16'h0000;
    localparam logic [15:0] PAT_RESET    = 16'h0000;
    localparam logic [15:0] READ_NONE    = 16'h0000;

    // ==========
    // Low-power state selection held in the sleep register.
    // ==========
    localparam logic [1:0]  PM_SHUTDOWN  = 2'h0;
    localparam logic [1:0]  PM_STANDBY   = 2'h1;
    localparam logic [1:0]  PM_DEEP      = 2'h2;
    localparam logic [1:0]  PM_LIGHT     = 2'h3;

    // ==========
    // Wake-up cycle counts at the 8 ns reference clock.
    // ==========
    localparam int  SHUTDOWN_CYC   = 312500;  // Full shutdown, 2.5 ms.
    localparam int  STANDBY_CYC    = 12500;   // Stand-by, 100 us.
    localparam int  DEEP_CYC       = 2500;    // Deep sleep, 20 us.
    localparam int  LIGHT_CYC      = 250;     // Light sleep, 2 us.
    localparam int  WAKE_CNT_W     = 19;

    // ==========
    // Power state machine, Gray coded along active, sleep, wake.
    // ==========
    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_SLEEP  = 2'b01,
        ST_WAKE   = 2'b11
    } adctp_power_type;

endpackage : adctp_pkg

/* File: hw/adctp_fifo.sv */
`timescale 1ns/1ps
// ==========
// Synchronous FIFO with valid and ready on both sides.
// ==========
module adctp_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    wr_ptr_next;
    logic [PW-1:0]    rd_ptr_reg;
    logic [PW-1:0]    rd_ptr_next;
    logic [PW:0]      count_reg;
    logic [PW:0]      count_next;
    logic             push;
    logic             pop;

    // Flags come from the count, so full and empty are never guessed.
    assign in_ready  = (count_reg != (PW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // ==========
    // Pointer and count update.
    // ==========
    always_comb
    begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next  = count_reg;
        if (push)
            wr_ptr_next = (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + PW'(1);
        if (pop)
            rd_ptr_next = (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + PW'(1);
        if (push && !pop)
            count_next = count_reg + (PW+1)'(1);
        else if (pop && !push)
            count_next = count_reg - (PW+1)'(1);
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
        end
    end

    // Storage needs no reset; it is read only where the count says valid.
    always_ff @(posedge ref_clk)
    begin
        if (push)
            mem_reg[wr_ptr_reg] <= in_data;
    end

endmodule : adctp_fifo

/* File: hw/adctp_ctrl.sv */
`timescale 1ns/1ps
// Function
// RULE_01 - Sleep register at 0x37 selects shutdown, stand-by, deep or light sleep.
// RULE_02 - Low enable pin enters selected sleep state; high enable runs normally.
// RULE_03 - After enable rises, output is valid within the chosen state's wake time.
// RULE_04 - Software clears mode bit one of register 0x01 before choosing a pattern.
// RULE_05 - Software writes all three pattern registers for every pattern choice.
// RULE_06 - Pattern words give all-zero or all-one samples as listed.
// RULE_07 - Pattern words give alternating 0xAAA/0x555 or 0xFFF/0x000 samples.
// RULE_08 - Custom constant: control top bits 10, sample in bits 13:2 of 0x3D.
// RULE_09 - For normal output, software sets mode bit one and zeroes pattern registers.
// RULE_10 - Each serial transfer is an 8-bit address word then a 16-bit data word.
// RULE_11 - Selected pattern replaces samples on both channels with unchanged bus timing; pattern words go in whenever the block is active and the FIFO has room.
module adctp_ctrl
    import adctp_pkg::*;
#(
    parameter int SHUTDOWN_WAKE_CYC = SHUTDOWN_CYC,
    parameter int STANDBY_WAKE_CYC  = STANDBY_CYC,
    parameter int FIFO_DEPTH        = 8
) (
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    input  wire logic                serial_select_n,
    input  wire logic                serial_clk,
    input  wire logic                serial_data_in,
    output logic                     serial_data_out,
    output logic                     serial_data_oe,
    input  wire logic                enable_pin,
    input  wire logic [SMP_BITS-1:0] chan_a_sample,
    input  wire logic [SMP_BITS-1:0] chan_b_sample,
    input  wire logic                sample_valid,
    output logic      [SMP_BITS-1:0] out_chan_a,
    output logic      [SMP_BITS-1:0] out_chan_b,
    output logic                     out_valid,
    input  wire logic                out_ready,
    output logic                     sleep_active,
    output logic                     pattern_active
);
    localparam int FW = 2 * SMP_BITS;

    // ==========
    // Pin synchronisers: two flops each, then a third stage for edges.
    // ==========
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic       sclk_prev_reg;
    logic       sel_n_s;
    logic       sclk_s;
    logic       din_s;
    logic       en_s;
    logic       sclk_rise;
    logic       sclk_fall;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // Select and enable reset to their idle levels, so release brings no false sleep.
            sync1_reg     <= 4'h9;
            sync2_reg     <= 4'h9;
            sclk_prev_reg <= 1'b0;
        end
        else
        begin
            sync1_reg     <= {enable_pin, serial_data_in, serial_clk, serial_select_n};
            sync2_reg     <= sync1_reg;
            sclk_prev_reg <= sync2_reg[1];
        end
    end

    assign sel_n_s   = sync2_reg[0];
    assign sclk_s    = sync2_reg[1];
    assign din_s     = sync2_reg[2];
    assign en_s      = sync2_reg[3];
    assign sclk_rise = !sel_n_s && sclk_s && !sclk_prev_reg;
    assign sclk_fall = !sel_n_s && !sclk_s && sclk_prev_reg;

    // ==========
    // Serial frame engine and register file.
    // ==========
    logic [FRAME_BITS-1:0] shift_reg;
    logic [FRAME_BITS-1:0] shift_next;
    logic [4:0]            bit_cnt_reg;
    logic [4:0]            bit_cnt_next;
    logic [DATA_BITS-1:0]  rd_shift_reg;
    logic [DATA_BITS-1:0]  rd_shift_next;
    logic                  sdo_reg;
    logic                  sdo_next;
    logic                  sdo_oe_reg;
    logic                  sdo_oe_next;
    logic [DATA_BITS-1:0]  mode_reg;
    logic [DATA_BITS-1:0]  mode_next;
    logic [DATA_BITS-1:0]  sleep_sel_reg;
    logic [DATA_BITS-1:0]  sleep_sel_next;
    logic [DATA_BITS-1:0]  pat_ctl_reg;
    logic [DATA_BITS-1:0]  pat_ctl_next;
    logic [DATA_BITS-1:0]  pat_val_reg;
    logic [DATA_BITS-1:0]  pat_val_next;
    logic [DATA_BITS-1:0]  pat_alt_reg;
    logic [DATA_BITS-1:0]  pat_alt_next;
    logic [ADDR_BITS-1:0]  addr_word;
    logic [ADDR_BITS-1:0]  reg_addr;
    logic [DATA_BITS-1:0]  wr_data;
    logic [DATA_BITS-1:0]  rd_data;
    logic                  rd_mode_reg;
    logic                  rd_mode_next;

    // The address word sits in the top of the frame; its top bit asks a read.
    assign addr_word = shift_reg[FRAME_BITS-2:DATA_BITS-1];
    assign reg_addr  = {1'b0, addr_word[RW_BIT-1:0]};
    assign wr_data   = {shift_reg[DATA_BITS-2:0], din_s};

    // Readback mux; the last address bit is still on the pin at the eighth edge.
    always_comb
    begin
        case ({1'b0, shift_reg[RW_BIT-2:0], din_s})
            ADDR_MODE:    rd_data = mode_reg;
            ADDR_SLEEP:   rd_data = sleep_sel_reg;
            ADDR_PAT_CTL: rd_data = pat_ctl_reg;
            ADDR_PAT_VAL: rd_data = pat_val_reg;
            ADDR_PAT_ALT: rd_data = pat_alt_reg;
            default:      rd_data = READ_NONE;
        endcase
    end

    // Frame progress: one bit per rising edge, read data on falling edges.
    always_comb
    begin
        shift_next     = shift_reg;
        bit_cnt_next   = bit_cnt_reg;
        rd_shift_next  = rd_shift_reg;
        sdo_next       = sdo_reg;
        sdo_oe_next    = sdo_oe_reg;
        mode_next      = mode_reg;
        sleep_sel_next = sleep_sel_reg;
        pat_ctl_next   = pat_ctl_reg;
        pat_val_next   = pat_val_reg;
        pat_alt_next   = pat_alt_reg;
        rd_mode_next   = rd_mode_reg;
        if (sel_n_s)
        begin
            // Deselect ends any frame, so a short frame never commits.
            bit_cnt_next = '0;
            sdo_oe_next  = 1'b0;
        end
        else if (sclk_rise && bit_cnt_reg < 5'(FRAME_BITS))
        begin
            shift_next   = {shift_reg[FRAME_BITS-2:0], din_s};
            bit_cnt_next = bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == '0)
                rd_mode_next = din_s;                                      // [RULE_10]
            if (bit_cnt_reg == 5'(ADDR_BITS - 1))
                rd_shift_next = rd_data;                                   // [RULE_10]
            if (bit_cnt_reg == 5'(FRAME_BITS - 1) && !addr_word[RW_BIT])
            begin
                case (reg_addr)                                            // [RULE_10]
                    ADDR_MODE:    mode_next      = wr_data;
                    ADDR_SLEEP:   sleep_sel_next = wr_data;                // [RULE_01]
                    ADDR_PAT_CTL: pat_ctl_next   = wr_data;
                    ADDR_PAT_VAL: pat_val_next   = wr_data;
                    ADDR_PAT_ALT: pat_alt_next   = wr_data;
                    default:      mode_next      = mode_reg;
                endcase
            end
        end
        else if (sclk_fall && rd_mode_reg && bit_cnt_reg >= 5'(ADDR_BITS)
                 && bit_cnt_reg < 5'(FRAME_BITS))
        begin
            sdo_next      = rd_shift_reg[DATA_BITS-1];
            sdo_oe_next   = 1'b1;
            rd_shift_next = {rd_shift_reg[DATA_BITS-2:0], 1'b0};
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shift_reg     <= '0;
            bit_cnt_reg   <= '0;
            rd_shift_reg  <= '0;
            sdo_reg       <= 1'b0;
            sdo_oe_reg    <= 1'b0;
            rd_mode_reg   <= 1'b0;
            mode_reg      <= MODE_RESET;
            sleep_sel_reg <= SLEEP_RESET;
            pat_ctl_reg   <= PAT_RESET;
            pat_val_reg   <= PAT_RESET;
            pat_alt_reg   <= PAT_RESET;
        end
        else
        begin
            shift_reg     <= shift_next;
            bit_cnt_reg   <= bit_cnt_next;
            rd_shift_reg  <= rd_shift_next;
            sdo_reg       <= sdo_next;
            sdo_oe_reg    <= sdo_oe_next;
            rd_mode_reg   <= rd_mode_next;
            mode_reg      <= mode_next;
            sleep_sel_reg <= sleep_sel_next;
            pat_ctl_reg   <= pat_ctl_next;
            pat_val_reg   <= pat_val_next;
            pat_alt_reg   <= pat_alt_next;
        end
    end

    assign serial_data_out = sdo_reg;
    assign serial_data_oe  = sdo_oe_reg;

    // ==========
    // Power state machine with wake-up timer.
    // ==========
    adctp_power_type        pstate_reg;
    adctp_power_type        pstate_next;
    logic [WAKE_CNT_W-1:0]  wake_cnt_reg;
    logic [WAKE_CNT_W-1:0]  wake_cnt_next;
    logic [WAKE_CNT_W-1:0]  wake_len;
    logic                   sleep_act_reg;
    logic                   sleep_act_next;

    // Wake length follows the selection in force when the pin rises.
    always_comb
    begin
        case (sleep_sel_reg[1:0])                                          // [RULE_03]
            PM_SHUTDOWN: wake_len = WAKE_CNT_W'(SHUTDOWN_WAKE_CYC);
            PM_STANDBY:  wake_len = WAKE_CNT_W'(STANDBY_WAKE_CYC);
            PM_DEEP:     wake_len = WAKE_CNT_W'(DEEP_CYC);
            PM_LIGHT:    wake_len = WAKE_CNT_W'(LIGHT_CYC);
            default:     wake_len = WAKE_CNT_W'(SHUTDOWN_WAKE_CYC);
        endcase
    end

    always_comb
    begin
        pstate_next    = pstate_reg;
        wake_cnt_next  = wake_cnt_reg;
        sleep_act_next = sleep_act_reg;
        case (pstate_reg)
            ST_ACTIVE:
            begin
                if (!en_s)
                begin
                    pstate_next    = ST_SLEEP;                             // [RULE_02]
                    sleep_act_next = 1'b1;
                end
            end
            ST_SLEEP:
            begin
                if (en_s)
                begin
                    pstate_next   = ST_WAKE;
                    wake_cnt_next = wake_len - WAKE_CNT_W'(1);             // [RULE_03]
                end
            end
            ST_WAKE:
            begin
                // Dropping the pin during wake goes straight back to sleep.
                if (!en_s)
                    pstate_next = ST_SLEEP;                                // [RULE_02]
                else if (wake_cnt_reg == '0)
                begin
                    pstate_next    = ST_ACTIVE;                            // [RULE_03]
                    sleep_act_next = 1'b0;
                end
                else
                    wake_cnt_next = wake_cnt_reg - WAKE_CNT_W'(1);
            end
            default:
            begin
                pstate_next    = ST_SLEEP;
                sleep_act_next = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pstate_reg    <= ST_ACTIVE;
            wake_cnt_reg  <= '0;
            sleep_act_reg <= 1'b0;
        end
        else
        begin
            pstate_reg    <= pstate_next;
            wake_cnt_reg  <= wake_cnt_next;
            sleep_act_reg <= sleep_act_next;
        end
    end

    assign sleep_active = sleep_act_reg;

    // ==========
    // Pattern source and data path into the FIFO.
    // ==========
    logic                pat_sel;
    logic                pat_toggle;
    logic                phase_reg;
    logic                phase_next;
    logic                pat_on_reg;
    logic                pat_on_next;
    logic [SMP_BITS-1:0] pat_word;
    logic                push_valid;
    logic                push_ready;
    logic [FW-1:0]       push_data;
    logic                fifo_valid;
    logic [FW-1:0]       fifo_data;
    logic                fifo_pop;
    logic [FW-1:0]       out_data_reg;
    logic [FW-1:0]       out_data_next;
    logic                out_valid_reg;
    logic                out_valid_next;

    // Control top bit selects the pattern; a nonzero control middle field
    // makes it alternate between the two value registers, else it is constant.
    assign pat_sel    = pat_ctl_reg[PAT_EN_BIT];                           // [RULE_06]
    assign pat_toggle = (pat_ctl_reg[SMP_MSB:SMP_LSB] != '0);              // [RULE_07]
    assign pat_word   = (pat_toggle && phase_reg) ? pat_alt_reg[SMP_MSB:SMP_LSB] // [RULE_07]
                                                  : pat_val_reg[SMP_MSB:SMP_LSB]; // [RULE_08]

    // A pattern waits for FIFO room; live samples cannot stall and are lost.
    assign push_valid = (pstate_reg == ST_ACTIVE) && (pat_sel || sample_valid);
    assign push_data  = pat_sel ? {pat_word, pat_word}                     // [RULE_11]
                                : {chan_a_sample, chan_b_sample};
    assign fifo_pop   = fifo_valid && (!out_valid_reg || out_ready);

    always_comb
    begin
        phase_next     = phase_reg;
        pat_on_next    = pat_sel;
        out_data_next  = out_data_reg;
        out_valid_next = out_valid_reg;
        if (!pat_sel)
            phase_next = 1'b0;
        else if (push_valid && push_ready)
            phase_next = !phase_reg;                                       // [RULE_07]
        if (fifo_pop)
        begin
            out_data_next  = fifo_data;
            out_valid_next = 1'b1;
        end
        else if (out_ready)
            out_valid_next = 1'b0;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_reg     <= 1'b0;
            pat_on_reg    <= 1'b0;
            out_data_reg  <= '0;
            out_valid_reg <= 1'b0;
        end
        else
        begin
            phase_reg     <= phase_next;
            pat_on_reg    <= pat_on_next;
            out_data_reg  <= out_data_next;
            out_valid_reg <= out_valid_next;
        end
    end

    adctp_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    assign out_chan_a     = out_data_reg[FW-1:SMP_BITS];
    assign out_chan_b     = out_data_reg[SMP_BITS-1:0];
    assign out_valid      = out_valid_reg;
    assign pattern_active = pat_on_reg;

endmodule : adctp_ctrl

/* File: testbench/adctp_ctrl_assertions.sv */
`timescale 1ns/1ps
// ==========
// Port checker for the pattern and sleep block.
module adctp_checker
    import adctp_pkg::*;
#(
    parameter int SHUTDOWN_WAKE_CYC = SHUTDOWN_CYC,
    parameter int STANDBY_WAKE_CYC  = STANDBY_CYC
) (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        serial_select_n,
    input wire logic        serial_data_oe,
    input wire logic        enable_pin,
    input wire logic [11:0] out_chan_a,
    input wire logic [11:0] out_chan_b,
    input wire logic        out_valid,
    input wire logic        out_ready,
    input wire logic        sleep_active,
    input wire logic        pattern_active
);
    // Slowest wake count, plus slack for the enable synchroniser.
    localparam int SLOW = SHUTDOWN_WAKE_CYC > STANDBY_WAKE_CYC ? SHUTDOWN_WAKE_CYC : STANDBY_WAKE_CYC;
    localparam int WAKE_MAX = (SLOW > DEEP_CYC ? SLOW : DEEP_CYC) + 8;
    logic [19:0] wait_reg;
    logic [19:0] wait_next;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // Cycles spent waking while the enable pin is already high.
    always_comb wait_next = (sleep_active && enable_pin) ? wait_reg + 20'h1 : 20'h0;
    always_ff @(posedge ref_clk or negedge rst_n)
        if (!rst_n)
            wait_reg <= 20'h0;
        else
            wait_reg <= wait_next;
    sequence s_stalled;
        out_valid && !out_ready;
    endsequence
    sequence s_idle_asleep;
        (sleep_active && !out_valid) [*3] ##1 sleep_active [*3];
    endsequence
    a_sleep_entry: assert property (!enable_pin [*8] |-> sleep_active)
        else $error("sleep flag missing while enable is low");
    a_sleep_quiet: assert property (s_idle_asleep |-> !out_valid)
        else $error("word delivered while asleep");
    a_wake_bound: assert property (wait_reg <= 20'(WAKE_MAX))
        else $error("wake took too long");
    a_wake_release: assert property ($fell(sleep_active) |-> enable_pin)
        else $error("woke with enable low");
    a_pattern_same: assert property (pattern_active && $past(pattern_active, 12) && out_valid
        |-> out_chan_a == out_chan_b)
        else $error("channels differ in pattern mode");
    a_stall_valid: assert property (s_stalled |=> out_valid)
        else $error("valid dropped while stalled");
    a_stall_data: assert property (s_stalled |=> $stable(out_chan_a) && $stable(out_chan_b))
        else $error("data changed while stalled");
    a_oe_idle: assert property (serial_select_n [*6] |-> !serial_data_oe)
        else $error("data pin driven outside a frame");
endmodule : adctp_checker

bind adctp_ctrl adctp_checker #(
    .SHUTDOWN_WAKE_CYC(SHUTDOWN_WAKE_CYC),
    .STANDBY_WAKE_CYC(STANDBY_WAKE_CYC)
) u_checker (.*);

/* File: testbench/adctp_sink.sv */
`timescale 1ns/1ps
// ==========
// Receiving logic that captures both buses and may stall.
module adctp_sink (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        stall,
    input wire logic [11:0] out_chan_a,
    input wire logic [11:0] out_chan_b,
    input wire logic        out_valid,
    output logic            out_ready
);
    logic [11:0] qa[$];
    logic [11:0] qb[$];
    // Ready follows the bench's stall request, so slow phases are real back-pressure.
    assign out_ready = !stall;
    // A pair counts only where valid and ready meet at a rising edge.
    always @(posedge ref_clk)
        if (rst_n && out_valid && out_ready)
        begin
            qa.push_back(out_chan_a);
            qb.push_back(out_chan_b);
        end
endmodule : adctp_sink

/* File: testbench/adc_test_pattern_and_sleep_ctrl_test.sv */
`timescale 1ns/1ps
`define CHECK(name, exp, got) \
    begin \
        checked++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("wrong value %s expected %h seen %h", name, exp, got); \
        end \
    end
// ==========
// Bench for the pattern and sleep block.
module adc_test_pattern_and_sleep_ctrl_test
    import adctp_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        serial_select_n = 1'b1;
    logic        serial_clk = 1'b0;
    logic        sdio = 1'b0;
    logic        enable_pin = 1'b1;
    logic        sample_valid = 1'b0;
    logic        stall = 1'b0;
    logic [11:0] chan_a_sample = 12'h000;
    wire  [11:0] chan_b_sample = ~chan_a_sample;
    logic [11:0] out_chan_a, out_chan_b;
    logic        serial_data_out, serial_data_oe, out_valid, out_ready, sleep_active, pattern_active;
    int          num_errors = 0;
    int          checked = 0;
    // The shared data pin carries whichever side has it enabled.
    wire         serial_data_in = serial_data_oe ? serial_data_out : sdio;
    logic [15:0] pat_tab [5][3] = '{'{16'h8000, 16'h0000, 16'h0000}, '{16'hBFFC, 16'h3FFC, 16'h3FFC},
        '{16'h9554, 16'h2AA8, 16'h1554}, '{16'hBFFC, 16'h0000, 16'h3FFC}, '{16'h8000, 16'h168C, 16'h0000}};
    logic [11:0] exp_tab [5][2] = '{'{12'h000, 12'h000}, '{12'hFFF, 12'hFFF}, '{12'hAAA, 12'h555},
        '{12'h000, 12'hFFF}, '{12'h5A3, 12'h5A3}};
    always #4 ref_clk = ~ref_clk;
    // Short wake counts keep the run brief.
    adctp_ctrl #(.SHUTDOWN_WAKE_CYC(40), .STANDBY_WAKE_CYC(20)) u_dut (.*);
    adctp_sink u_sink (.*);
    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : wt
    // One frame: address word then data word, MSB first, slow enough for the synchroniser.
    task automatic sif(input logic [7:0] aw, input logic [15:0] wd, output logic [15:0] rd);
        logic [23:0] fr = {aw, wd};
        rd = 16'h0000;
        serial_select_n = 1'b0;
        wt(5);
        for (int i = 23; i >= 0; i--)
        begin
            sdio = fr[i];
            wt(5);
            rd = (i < 16) ? {rd[14:0], serial_data_in} : rd;
            serial_clk = 1'b1;
            wt(5);
            serial_clk = 1'b0;
        end
        wt(5);
        serial_select_n = 1'b1;
        wt(6);
    endtask : sif
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] r;
        sif(a, d, r);
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] r;
        sif(8'h80 | a, 16'h0000, r);
        `CHECK("register", exp, r)
    endtask : rchk
    task automatic t_regs;
        rchk(ADDR_PAT_CTL, PAT_RESET);
        rchk(ADDR_MODE, MODE_RESET);
        for (int m = 0; m < 4; m++)
        begin
            wr(ADDR_SLEEP, 16'(m));
            rchk(ADDR_SLEEP, 16'(m));
        end
        wr(8'h10, 16'hFFFF);
        rchk(8'h10, READ_NONE);
        $display("register test done");
    endtask : t_regs
    task automatic t_pattern;
        int ph;
        wr(ADDR_MODE, 16'h0000);
        for (int p = 0; p < 5; p++)
        begin
            wr(ADDR_PAT_CTL, pat_tab[p][0]);
            wr(ADDR_PAT_VAL, pat_tab[p][1]);
            wr(ADDR_PAT_ALT, pat_tab[p][2]);
            wt(20);
            u_sink.qa.delete();
            u_sink.qb.delete();
            wt(12);
            ph = (u_sink.qa[0] === exp_tab[p][0]) ? 0 : 1;
            for (int i = 0; i < 4; i++)
            begin
                `CHECK("chan a", exp_tab[p][(i + ph) % 2], u_sink.qa[i])
                `CHECK("chan b", exp_tab[p][(i + ph) % 2], u_sink.qb[i])
            end
        end
        wr(ADDR_MODE, MODE_RESET);
        wr(ADDR_PAT_CTL, 16'h0000);
        wr(ADDR_PAT_VAL, 16'h0000);
        wr(ADDR_PAT_ALT, 16'h0000);
        `CHECK("pattern flag", 1'b0, pattern_active)
        $display("pattern test done");
    endtask : t_pattern
    task automatic t_fill;
        wt(20);
        u_sink.qa.delete();
        u_sink.qb.delete();
        stall = 1'b1;
        sample_valid = 1'b1;
        for (int i = 0; i < 12; i++)
        begin
            chan_a_sample = 12'h100 + 12'(i);
            wt(1);
        end
        sample_valid = 1'b0;
        wt(5);
        stall = 1'b0;
        wt(20);
        `CHECK("words kept", 9, u_sink.qa.size())
        for (int i = 0; i < 9; i++)
        begin
            `CHECK("normal a", 12'h100 + 12'(i), u_sink.qa[i])
            `CHECK("normal b", ~(12'h100 + 12'(i)), u_sink.qb[i])
        end
        $display("buffer test done");
    endtask : t_fill
    task automatic t_sleep;
        int wk [4] = '{40, 20, DEEP_CYC, LIGHT_CYC};
        int n;
        for (int m = 0; m < 4; m++)
        begin
            wr(ADDR_SLEEP, 16'(m));
            enable_pin = 1'b0;
            wt(10);
            `CHECK("sleep flag", 1'b1, sleep_active)
            u_sink.qa.delete();
            sample_valid = 1'b1;
            wt(4);
            sample_valid = 1'b0;
            enable_pin = 1'b1;
            n = 0;
            while (sleep_active !== 1'b0 && n < 3000)
            begin
                wt(1);
                n++;
            end
            `CHECK("wake time", 1'b1, n >= wk[m] && n <= wk[m] + 8)
            `CHECK("words asleep", 0, u_sink.qa.size())
        end
        $display("sleep test done");
    endtask : t_sleep
    task automatic finish_test;
        $display("checked %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    // Watchdog sized at about three times the expected run.
    initial
    begin
        #300us;
        num_errors++;
        finish_test();
    end
    initial
    begin
        wt(8);
        rst_n = 1'b1;
        wt(4);
        t_regs();
        t_pattern();
        t_fill();
        t_sleep();
        finish_test();
    end
endmodule : adc_test_pattern_and_sleep_ctrl_test
